//--- hw/flash_cfg_pkg.sv
// Constants, enumerations and carriers of the flash segment and configuration loader.
package flash_cfg_pkg;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int ADDR_W = 25;
    localparam int HALF_W = 24;
    localparam int SEG_W = 8;
    localparam int CFG_W = 16;
    localparam int SEG_BIT = 0;

    // ****************************************
    // Persistent configuration field positions
    // ****************************************
    localparam int DUMMY_LSB = 12;
    localparam int EXEC_LSB = 9;
    localparam int DRIVE_LSB = 6;
    localparam int DTR_BIT = 5;
    localparam int LINE3_BIT = 4;
    localparam int QUAD_BIT = 3;
    localparam int DUAL_BIT = 2;
    localparam int SEGDEF_BIT = 1;
    localparam int ALEN_BIT = 0;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [15:0] CFG_RESET = 16'hFFFF;
    localparam logic [7:0] SEG_RESET = 8'h00;
    localparam logic [3:0] DUMMY_ZERO = 4'h0;
    localparam logic [3:0] DUMMY_MAX = 4'hF;
    localparam logic [2:0] EXEC_OFF = 3'h7;
    localparam logic [2:0] EXEC_LAST = 3'h4;
    localparam logic [2:0] DRIVE_DEF = 3'h7;

    typedef enum logic [1:0] {
        OP_READ,
        OP_PROGRAM,
        OP_SECTOR_ERASE,
        OP_BULK_ERASE
    } op_t;

    typedef enum logic [1:0] {
        SEL_SEGMENT,
        SEL_PERSIST,
        SEL_VOLATILE,
        SEL_ENH_VOLATILE
    } reg_sel_t;

    typedef struct packed {
        reg_sel_t sel;
        logic [15:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic [3:0] dummy_cycles;
        logic exec_en;
        logic [2:0] exec_mode;
        logic [2:0] drive;
        logic dtr_en;
        logic line3_en;
        logic quad_en;
        logic dual_en;
        logic four_byte;
    } cfg_t;

endpackage : flash_cfg_pkg

//--- hw/flash_segment_and_config_loader.sv
// Segment select, persistent configuration and internal configuration loader of a serial flash.
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] 3-byte mode: segment bit is address bit 24
// [R2] Segment bits 7:1 held at zero
// [R3] 4-byte mode ignores the segment register
// [R4] Segment reset value from persistent bit 1; lk_segment_rd keeps its old value until the next link write
// [R5] Program and sector erase stay in half
// [R6] Bulk erase covers the whole array
// [R7] Read crosses halves, wraps to zero
// [R8] Read crossing leaves segment register unchanged
// [R9] Internal configuration hidden from the host
// [R10] Reset copies persistent into internal configuration
// [R11] Volatile writes load internal configuration at completion
// [R12] Bits 15:12 give dummy count, 0/15 default
// [R13] Bits 11:9 give execute-in-place read type
// [R14] Bits 8:6 give drive strength, even reserved
// [R15] Bit 5 low selects double transfer rate
// [R16] Bit 4 enables pause/reset on line three
// [R17] Bit 3 low enables four-line protocol
// [R18] Bit 2 low enables two-line protocol
// [R19] Four-line wins when both enabled
// [R20] Bit 0 picks 4-byte or 3-byte addresses
// [R21] Host must program enough dummy cycles
// [R22] Flag bit 0 shows address length
// [R23] New configuration applies from next command

module flash_segment_and_config_loader #(
    parameter logic [15:0] PERSIST_INIT = flash_cfg_pkg::CFG_RESET,
    parameter logic [3:0] DUMMY_DEFAULT = 4'hA
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic soft_reset,
    // Link side register commands
    input wire logic link_clk,
    input wire logic link_rst_n,
    input wire logic lk_wr_valid,
    input wire flash_cfg_pkg::reg_wr_t lk_wr,
    output logic lk_wr_ready,
    output logic [7:0] lk_segment_rd,
    output logic [15:0] lk_persist_rd,
    // Array command
    input wire logic cmd_valid,
    input wire flash_cfg_pkg::op_t cmd_op,
    input wire logic [31:0] cmd_addr,
    input wire logic rd_next,
    output logic cmd_go,
    output flash_cfg_pkg::op_t op_out,
    output logic [flash_cfg_pkg::ADDR_W-1:0] array_addr,
    output logic erase_all,
    // Active configuration
    output flash_cfg_pkg::cfg_t cfg_active,
    output logic flag_four_byte,
    output logic cfg_ready
);

    // ****************************************
    // Shared state
    // ****************************************
    // These registers are read by both sections below, so they are declared first.
    // The loader has two states: a one-cycle download of the persistent word, then normal running.
    typedef enum logic {
        ST_LOAD,
        ST_RUN
    } state_t;

    state_t state_q;
    // Ack toggle of the core side; it moves on the same clk edge that loads the snapshots.
    logic ack_q;
    // Snapshots of segment and persistent word, read by the link side after the ack toggle is seen.
    // Keeping separate copies means the link never samples seg_q or nv_q while they change.
    logic [7:0] snap_seg_q;
    logic [15:0] snap_nv_q;

    // ****************************************
    // Link domain: write capture
    // ****************************************
    flash_cfg_pkg::reg_wr_t lk_hold_q;
    logic lk_req_q;
    logic lk_ack_s1_q;
    logic lk_ack_s2_q;
    logic lk_ack_seen_q;
    logic lk_busy;

    // A write is held until the core returns the toggle.
    assign lk_busy = lk_req_q != lk_ack_seen_q;

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk_hold_q <= '0;
            lk_req_q <= 1'b0;
        end else if (lk_wr_valid && !lk_busy) begin
            lk_hold_q <= lk_wr;
            lk_req_q <= ~lk_req_q;
        end
    end

    // Two flops bring the ack toggle in; a third remembers the last one seen.
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk_ack_s1_q <= 1'b0;
            lk_ack_s2_q <= 1'b0;
            lk_ack_seen_q <= 1'b0;
        end else begin
            lk_ack_s1_q <= ack_q;
            lk_ack_s2_q <= lk_ack_s1_q;
            lk_ack_seen_q <= lk_ack_s2_q;
        end
    end

    // Ready drops on the edge that takes a write, so a valid held one cycle too long
    // is never taken twice.
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk_wr_ready <= 1'b0;
        end else begin
            lk_wr_ready <= !(lk_wr_valid && !lk_busy) && (lk_req_q == lk_ack_s2_q);
        end
    end

    // Snapshots are stable for two link edges before the ack toggle is seen.
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk_segment_rd <= flash_cfg_pkg::SEG_RESET;
            lk_persist_rd <= flash_cfg_pkg::CFG_RESET;
        end else if (lk_ack_s2_q != lk_ack_seen_q) begin
            lk_segment_rd <= snap_seg_q;
            lk_persist_rd <= snap_nv_q;
        end
    end

    // ****************************************
    // Core domain: request crossing
    // ****************************************
    logic req_s1_q;
    logic req_s2_q;
    logic req_seen_q;
    logic wr_take;

    // The synchroniser freezes with ce as well; a request simply waits
    // until the core runs again.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else if (ce) begin
            req_s1_q <= lk_req_q;
            req_s2_q <= req_s1_q;
        end
    end

    // Writes wait while the reset download is still pending.
    assign wr_take = ce && (req_s2_q != req_seen_q) && (state_q == ST_RUN);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_seen_q <= 1'b0;
        end else if (wr_take) begin
            req_seen_q <= req_s2_q;
        end
    end

    // ****************************************
    // Loader state
    // ****************************************
    // A soft reset costs one download cycle, during which writes wait and commands are dropped.
    // The persistent word itself is not touched by the download.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_LOAD;
        end else if (ce) begin
            case (state_q)
                ST_LOAD: begin
                    state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (soft_reset) begin
                        state_q <= ST_LOAD;
                    end
                end
                default: begin
                    state_q <= ST_LOAD;
                end
            endcase
        end
    end

    // ****************************************
    // Persistent configuration and segment
    // ****************************************
    logic [15:0] nv_q;
    logic [7:0] seg_q;

    // The persistent word survives a soft reset; only rst_n restores it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_q <= PERSIST_INIT;
        end else if (wr_take && lk_hold_q.sel == flash_cfg_pkg::SEL_PERSIST) begin
            nv_q <= lk_hold_q.data;
        end
    end

    // A download has priority over a segment write; writes are held off in ST_LOAD,
    // so the two never meet in practice.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_q <= flash_cfg_pkg::SEG_RESET;
        end else if (ce && state_q == ST_LOAD) begin
            seg_q <= {7'h00, ~nv_q[flash_cfg_pkg::SEGDEF_BIT]}; // see [R4]
        end else if (wr_take && lk_hold_q.sel == flash_cfg_pkg::SEL_SEGMENT) begin
            seg_q <= {7'h00, lk_hold_q.data[flash_cfg_pkg::SEG_BIT]}; // see [R2]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_seg_q <= flash_cfg_pkg::SEG_RESET;
            snap_nv_q <= flash_cfg_pkg::CFG_RESET;
            ack_q <= 1'b0;
        end else if (wr_take) begin
            snap_seg_q <= (lk_hold_q.sel == flash_cfg_pkg::SEL_SEGMENT) ?
                {7'h00, lk_hold_q.data[flash_cfg_pkg::SEG_BIT]} : seg_q;
            snap_nv_q <= (lk_hold_q.sel == flash_cfg_pkg::SEL_PERSIST) ?
                lk_hold_q.data : nv_q;
            ack_q <= req_s2_q;
        end
    end

    // ****************************************
    // Internal configuration
    // ****************************************
    // Read by no link path; written by the download and by volatile link writes.
    logic [15:0] icr_q; // see [R9]
    logic icr_new_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            icr_q <= flash_cfg_pkg::CFG_RESET;
        end else if (ce && state_q == ST_LOAD) begin
            icr_q <= nv_q; // see [R10]
        end else if (wr_take && lk_hold_q.sel[1]) begin
            icr_q <= lk_hold_q.data; // see [R11]
        end
    end

    // A volatile write and a command in the same cycle leave the flag set: the command
    // still used the old word, so the new one has not yet been applied.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            icr_new_q <= 1'b1;
        end else if (ce) begin
            if (state_q == ST_LOAD || (wr_take && lk_hold_q.sel[1])) begin
                icr_new_q <= 1'b1;
            end else if (cmd_valid) begin
                icr_new_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Field decode
    // ****************************************
    flash_cfg_pkg::cfg_t dec;
    logic [3:0] dcode;
    logic [2:0] ecode;
    logic [2:0] rcode;

    always_comb begin
        dcode = icr_q[flash_cfg_pkg::DUMMY_LSB +: 4];
        ecode = icr_q[flash_cfg_pkg::EXEC_LSB +: 3];
        rcode = icr_q[flash_cfg_pkg::DRIVE_LSB +: 3];
        dec = '0;
        if (dcode == flash_cfg_pkg::DUMMY_ZERO || dcode == flash_cfg_pkg::DUMMY_MAX) begin
            dec.dummy_cycles = DUMMY_DEFAULT; // see [R12]
        end else begin
            dec.dummy_cycles = dcode;
        end
        // Reserved read types leave execute-in-place off.
        dec.exec_en = ecode <= flash_cfg_pkg::EXEC_LAST; // see [R13]
        dec.exec_mode = ecode;
        // Even drive codes are reserved and fall back to the default strength.
        dec.drive = rcode[0] ? rcode : flash_cfg_pkg::DRIVE_DEF; // see [R14]
        dec.dtr_en = !icr_q[flash_cfg_pkg::DTR_BIT]; // see [R15]
        dec.line3_en = icr_q[flash_cfg_pkg::LINE3_BIT]; // see [R16]
        dec.quad_en = !icr_q[flash_cfg_pkg::QUAD_BIT]; // see [R17]
        dec.dual_en = !icr_q[flash_cfg_pkg::DUAL_BIT] && icr_q[flash_cfg_pkg::QUAD_BIT]; // see [R18] [R19]
        dec.four_byte = !icr_q[flash_cfg_pkg::ALEN_BIT]; // see [R20]
    end

    // ****************************************
    // Active configuration
    // ****************************************
    // A load never reshapes a command already under way.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_active <= '0;
            flag_four_byte <= 1'b0;
        end else if (ce && cmd_valid && state_q == ST_RUN) begin
            cfg_active <= dec; // see [R23]
            flag_four_byte <= dec.four_byte; // see [R22]
        end
    end

    // Ready lags the clearing of the new-load flag by one cycle because it is
    // itself a register, as every output is.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ready <= 1'b0;
        end else if (ce) begin
            cfg_ready <= state_q == ST_RUN && !icr_new_q;
        end
    end

    // ****************************************
    // Address path
    // ****************************************
    logic [flash_cfg_pkg::ADDR_W-1:0] base_addr;

    always_comb begin
        if (dec.four_byte) begin
            base_addr = cmd_addr[flash_cfg_pkg::ADDR_W-1:0]; // see [R3]
        end else begin
            base_addr = {seg_q[flash_cfg_pkg::SEG_BIT], cmd_addr[flash_cfg_pkg::HALF_W-1:0]}; // see [R1] [R5]
        end
        if (cmd_op == flash_cfg_pkg::OP_BULK_ERASE) begin
            base_addr = '0; // see [R6]
        end
    end

    // Commands that arrive during the download cycle are dropped, not queued;
    // the host sees no cmd_go for them.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_go <= 1'b0;
        end else if (ce) begin
            cmd_go <= cmd_valid && state_q == ST_RUN;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_out <= flash_cfg_pkg::OP_READ;
            erase_all <= 1'b0;
        end else if (ce && cmd_valid && state_q == ST_RUN) begin
            op_out <= cmd_op;
            erase_all <= cmd_op == flash_cfg_pkg::OP_BULK_ERASE; // see [R6]
        end
    end

    // The read counter runs over the full array; seg_q is never touched here.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            array_addr <= '0;
        end else if (ce && cmd_valid && state_q == ST_RUN) begin
            array_addr <= base_addr;
        end else if (ce && rd_next && op_out == flash_cfg_pkg::OP_READ) begin
            array_addr <= array_addr + 1'b1; // see [R7] [R8]
        end
    end

endmodule : flash_segment_and_config_loader

`default_nettype wire

//--- verification/flash_loader_props.sv
// Concurrent checks on the ports of the segment and configuration loader.
`timescale 1ns/1ps
`default_nettype none
module flash_loader_props (
    // Core clock, reset and requests
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_addr,
    input wire logic rd_next,
    // Results
    input wire logic cmd_go,
    input wire flash_cfg_pkg::op_t op_out,
    input wire logic [flash_cfg_pkg::ADDR_W-1:0] array_addr,
    input wire logic erase_all,
    input wire flash_cfg_pkg::cfg_t cfg_active,
    input wire logic flag_four_byte,
    input wire logic [7:0] lk_segment_rd
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Command and address checks
    // ****************************************
    AST_GO_CAUSE: assert property (cmd_go |-> $past(cmd_valid && ce))
        else $error("cmd_go without a request");
    AST_ADDR_THREE: assert property (cmd_go && !flag_four_byte && !erase_all
        |-> array_addr[23:0] == $past(cmd_addr[23:0]))
        else $error("3-byte address bits wrong");
    AST_ADDR_FOUR: assert property (cmd_go && flag_four_byte && !erase_all
        |-> array_addr == $past(cmd_addr[24:0]))
        else $error("4-byte address wrong");
    AST_BULK: assert property (cmd_go |-> erase_all == (op_out == flash_cfg_pkg::OP_BULK_ERASE))
        else $error("bulk erase flag wrong");
    AST_BULK_ADDR: assert property (cmd_go && erase_all |-> array_addr == 25'h0)
        else $error("bulk erase address not zero");
    AST_READ_STEP: assert property (rd_next && ce && !cmd_valid && op_out == flash_cfg_pkg::OP_READ
        |=> array_addr == $past(array_addr) + 25'h1)
        else $error("read address did not step");
    AST_SEG_UPPER: assert property (lk_segment_rd[7:1] == 7'h00)
        else $error("segment upper bits not zero");
    // ****************************************
    // Decoded configuration checks
    // ****************************************
    AST_FLAG: assert property (cmd_go |-> flag_four_byte == cfg_active.four_byte)
        else $error("address length flag disagrees");
    AST_DUMMY: assert property (cmd_go |-> cfg_active.dummy_cycles != 4'h0 && cfg_active.dummy_cycles != 4'hF)
        else $error("dummy count not decoded");
    AST_DRIVE: assert property (cmd_go |-> cfg_active.drive[0])
        else $error("reserved drive code active");
    AST_QUAD_WINS: assert property (cmd_go |-> !(cfg_active.quad_en && cfg_active.dual_en))
        else $error("two protocols active");
    AST_EXEC: assert property (cmd_go |-> cfg_active.exec_en == (cfg_active.exec_mode <= 3'h4))
        else $error("execute-in-place enable wrong");
    COV_BULK: cover property (cmd_go && erase_all);
    COV_FOUR: cover property (cmd_go && flag_four_byte);
    COV_WRAP: cover property (array_addr == 25'h0 && $past(array_addr) == 25'h1FFFFFF);
endmodule : flash_loader_props
bind flash_segment_and_config_loader flash_loader_props flash_loader_props_inst (.clk, .rst_n, .ce, .cmd_valid,
    .cmd_addr, .rd_next, .cmd_go, .op_out, .array_addr, .erase_all, .cfg_active, .flag_four_byte, .lk_segment_rd);
`default_nettype wire

//--- verification/flash_host_model.sv
// Host controller model that issues register writes on the link clock.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    // Link clock and handshake
    input wire logic link_clk,
    input wire logic lk_wr_ready,
    output logic lk_wr_valid,
    output flash_cfg_pkg::reg_wr_t lk_wr
);
    initial begin
        lk_wr_valid = 1'b0;
        lk_wr = '0;
    end
    // The caller picks dummy codes long enough for its read clock.
    task automatic put(input flash_cfg_pkg::reg_sel_t sel, input logic [15:0] data);
        int n;
        @(negedge link_clk);
        for (n = 0; n < 40 && lk_wr_ready !== 1'b1; n++) @(negedge link_clk);
        lk_wr_valid = 1'b1;
        lk_wr = '{sel: sel, data: data};
        // The rising edge in between sees ready high and takes the word.
        @(negedge link_clk);
        lk_wr_valid = 1'b0;
        // Released data is scrambled so nothing relies on a stale word.
        lk_wr = ~lk_wr;
        @(negedge link_clk);
        for (n = 0; n < 40 && lk_wr_ready !== 1'b1; n++) @(negedge link_clk);
    endtask : put
endmodule : flash_host_model
`default_nettype wire

//--- verification/flash_segment_and_config_loader_tb.sv
// Self-checking bench of the segment and configuration loader.
`timescale 1ns/1ps
`default_nettype none
module flash_segment_and_config_loader_tb;
    localparam logic [3:0] DUMMY_DEF = 4'hA;
    localparam logic [15:0] NV_WORD = 16'h38C1;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_rst_n = 1'b0;
    logic ce = 1'b1;
    logic soft_reset = 1'b0;
    logic cmd_valid = 1'b0;
    flash_cfg_pkg::op_t cmd_op = flash_cfg_pkg::OP_READ;
    logic [31:0] cmd_addr = 32'h0;
    logic rd_next = 1'b0;
    logic lk_wr_valid, lk_wr_ready, cmd_go, erase_all, flag_four_byte, cfg_ready;
    flash_cfg_pkg::reg_wr_t lk_wr;
    logic [7:0] lk_segment_rd;
    logic [15:0] lk_persist_rd;
    flash_cfg_pkg::op_t op_out;
    logic [24:0] array_addr;
    flash_cfg_pkg::cfg_t cfg_active;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    always #15 link_clk = ~link_clk;
    flash_segment_and_config_loader #(.DUMMY_DEFAULT(DUMMY_DEF)) flash_segment_and_config_loader_inst (.clk, .rst_n,
        .ce, .soft_reset, .link_clk, .link_rst_n, .lk_wr_valid, .lk_wr, .lk_wr_ready, .lk_segment_rd, .lk_persist_rd,
        .cmd_valid, .cmd_op, .cmd_addr, .rd_next, .cmd_go, .op_out, .array_addr, .erase_all, .cfg_active,
        .flag_four_byte, .cfg_ready);
    flash_host_model flash_host_model_inst (.link_clk, .lk_wr_ready, .lk_wr_valid, .lk_wr);
    // ****************************************
    // Compare and drive helpers
    // ****************************************
    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val
    task automatic chk_cfg(input string name, input flash_cfg_pkg::cfg_t exp, input flash_cfg_pkg::cfg_t got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_cfg
    function automatic flash_cfg_pkg::cfg_t expcfg(input logic [15:0] w);
        flash_cfg_pkg::cfg_t c;
        c.dummy_cycles = (w[15:12] == 4'h0 || w[15:12] == 4'hF) ? DUMMY_DEF : w[15:12];
        c.exec_mode = w[11:9];
        c.exec_en = w[11:9] <= 3'h4;
        c.drive = w[6] ? w[8:6] : 3'h7;
        c.dtr_en = !w[5];
        c.line3_en = w[4];
        c.quad_en = !w[3];
        c.dual_en = !w[2] && w[3];
        c.four_byte = !w[0];
        return c;
    endfunction : expcfg
    task automatic issue(input flash_cfg_pkg::op_t op, input logic [31:0] addr, input logic go);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = addr;
        @(negedge clk);
        cmd_valid = 1'b0;
        chk_val("cmd_go", go, cmd_go);
    endtask : issue
    task automatic step();
        @(negedge clk);
        rd_next = 1'b1;
        @(negedge clk);
        rd_next = 1'b0;
    endtask : step
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_power_on();
        ce = 1'b0;
        issue(flash_cfg_pkg::OP_READ, 32'h00123456, 1'b0);
        ce = 1'b1;
        issue(flash_cfg_pkg::OP_READ, 32'hFF123456, 1'b1);
        chk_val("addr", 25'h0123456, array_addr);
        chk_cfg("cfg", expcfg(16'hFFFF), cfg_active);
        chk_val("flag", 0, flag_four_byte);
        // Ready is registered one cycle behind the command that applied the load.
        @(negedge clk);
        chk_val("cfg_ready", 1, cfg_ready);
    endtask : t_power_on
    task automatic t_reload();
        flash_host_model_inst.put(flash_cfg_pkg::SEL_PERSIST, NV_WORD);
        @(negedge clk);
        chk_val("persist", NV_WORD, lk_persist_rd);
        issue(flash_cfg_pkg::OP_READ, 32'h0, 1'b1);
        chk_cfg("cfg", expcfg(16'hFFFF), cfg_active);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        repeat (2) @(negedge clk);
        issue(flash_cfg_pkg::OP_READ, 32'hFFFFFF, 1'b1);
        chk_val("addr", 25'h1FFFFFF, array_addr);
        chk_cfg("cfg", expcfg(NV_WORD), cfg_active);
        step();
        chk_val("wrap", 25'h0, array_addr);
    endtask : t_reload
    task automatic t_segment();
        flash_host_model_inst.put(flash_cfg_pkg::SEL_SEGMENT, 16'h0003);
        @(negedge clk);
        chk_val("segment", 8'h01, lk_segment_rd);
        flash_host_model_inst.put(flash_cfg_pkg::SEL_SEGMENT, 16'hFFFE);
        @(negedge clk);
        chk_val("segment", 8'h00, lk_segment_rd);
        issue(flash_cfg_pkg::OP_PROGRAM, 32'h000010, 1'b1);
        chk_val("prog", 25'h0000010, array_addr);
        chk_val("erase_all", 0, erase_all);
        issue(flash_cfg_pkg::OP_SECTOR_ERASE, 32'hABCDEF, 1'b1);
        chk_val("erase", 25'h0ABCDEF, array_addr);
        issue(flash_cfg_pkg::OP_BULK_ERASE, 32'h123456, 1'b1);
        chk_val("erase_all", 1, erase_all);
        issue(flash_cfg_pkg::OP_READ, 32'hFFFFFF, 1'b1);
        step();
        chk_val("cross", 25'h1000000, array_addr);
        issue(flash_cfg_pkg::OP_READ, 32'h5, 1'b1);
        chk_val("after cross", 25'h0000005, array_addr);
    endtask : t_segment
    task automatic t_volatile();
        logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
        logic [15:0] w;
        flash_host_model_inst.put(flash_cfg_pkg::SEL_VOLATILE, 16'h0EBE);
        issue(flash_cfg_pkg::OP_READ, 32'h01ABCDEF, 1'b1);
        chk_val("addr", 25'h1ABCDEF, array_addr);
        chk_val("flag", 1, flag_four_byte);
        chk_cfg("cfg", expcfg(16'h0EBE), cfg_active);
        for (int i = 0; i < 4; i++) begin
            w = {codes[i], 12'hFFB};
            flash_host_model_inst.put(flash_cfg_pkg::SEL_ENH_VOLATILE, w);
            issue(flash_cfg_pkg::OP_READ, 32'h1000020, 1'b1);
            chk_val("addr", 25'h0000020, array_addr);
            chk_cfg("cfg", expcfg(w), cfg_active);
        end
        chk_val("persist", NV_WORD, lk_persist_rd);
    endtask : t_volatile
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        link_rst_n = 1'b1;
        t_power_on();
        t_reload();
        t_segment();
        t_volatile();
        complete_run();
    end
endmodule : flash_segment_and_config_loader_tb
`default_nettype wire
